// >>> rtl/sdf_cfg.svh
/*
 * Constants of the sigma-delta decimation filter control block: register
 * address, field positions, reset value, rate and timing figures.
 * Assumes a 125 MHz system clock and a 32-bit register address.
 */
// Contract
// - Config write resets converters, 60 us each startup
// - Chop bit cuts rate to third; code leaves rate unchanged at decimation 126, 127
// - Nonzero averaging factor: chop keeps same rate
// - Chop settles in two output periods
// - Running average forced on while chopping
// - Running average adds one settling period
// - Averaging factor divides rate by three plus factor; code ignores factor at decimation 126, 127
// - Bit 7 adds second notch to response
// - Rate is 512000 over 64 times decimation plus one
// - Decimation 126 gives 60 Hz, 127 gives 50 Hz
// - Slowest rate 4 Hz normal, 1 Hz low power
// - Low power modes tick filter at 131 kHz
`ifndef SDF_CFG_SVH
`define SDF_CFG_SVH

// Register map
`define SDF_CFG_ADDR        32'hffff0518
`define SDF_CFG_RESET       16'h0007

// Field positions of the filter configuration register
`define SDF_CHOP_BIT        15
`define SDF_RUNAVG_BIT      14
`define SDF_AF_MSB          13
`define SDF_AF_LSB          8
`define SDF_NOTCH_BIT       7
`define SDF_SF_MSB          6
`define SDF_SF_LSB          0

// Clock and modulator rates in Hz; SDF_CLK_MHZ in MHz
`define SDF_CLK_HZ          27'd125000000
`define SDF_MOD_HZ          27'd512000
`define SDF_LP_HZ           27'd131000
`define SDF_MOD_HZ_INT      512000
`define SDF_CLK_MHZ         125

// Decimation figures
`define SDF_BASE_MUL        64
`define SDF_AF_OFFSET       3
`define SDF_SF_60HZ         7'd126
`define SDF_SF_50HZ         7'd127
`define SDF_RATE_60HZ       60
`define SDF_RATE_50HZ       50
`define SDF_MIN_RATE_HZ     4
`define SDF_PERIOD_60HZ     (`SDF_MOD_HZ_INT / `SDF_RATE_60HZ)
`define SDF_PERIOD_50HZ     (`SDF_MOD_HZ_INT / `SDF_RATE_50HZ)
`define SDF_PERIOD_MAX      (`SDF_MOD_HZ_INT / `SDF_MIN_RATE_HZ)

// Startup wait per enabled converter
`define SDF_STARTUP_US      60
`define SDF_STARTUP_CYCLES  (`SDF_STARTUP_US * `SDF_CLK_MHZ)

// Settling in output periods
`define SDF_SETTLE_PLAIN    3'd3
`define SDF_SETTLE_AVG      3'd4
`define SDF_SETTLE_CHOP     3'd2
`define SDF_SETTLE_RUNAVG   3'd1

`endif

// >>> rtl/sdf_ctrl.sv
/*
 * Decimation filter control for the current, voltage and temperature
 * converters: holds the filter configuration register, resets the
 * converters on every write to its address, waits out their startup, then paces output
 * results at the configured rate and reports settling.
 * Assumes converter enables and power mode come from logic on the same
 * clock, and a register master that never issues both strobes at once.
 */
`timescale 1ns/1ns
`default_nettype none

`include "sdf_cfg.svh"

module sdf_ctrl
   import sdf_pkg::*;
#(
   parameter int STARTUP_CYCLES = `SDF_STARTUP_CYCLES  // Per converter
)
(
   input  wire logic        i_clock,        // System clock, 125 MHz
   input  wire logic        i_rst,          // Synchronous reset
   input  wire logic [31:0] i_addr,         // Register byte address
   input  wire logic [15:0] i_wr_data,      // Register write data
   input  wire logic        i_wr,           // Write strobe
   input  wire logic        i_rd,           // Read strobe
   input  wire logic [2:0]  i_adc_enable,   // Current, voltage, temp on
   input  wire logic        i_lp_mode,      // Low power modes
   output logic      [15:0] o_rd_data,      // Read data, cycle after read
   output logic             o_conv_reset,   // Converter reset pulse
   output logic             o_mod_tick,     // Modulator tick enable
   output logic             o_result,       // Output result pulse
   output logic             o_settled,      // Filter settled
   output logic             o_chop,         // System chopping active
   output logic             o_chop_phase,   // Chop input polarity
   output logic             o_run_avg,      // Average-by-2 active
   output logic             o_second_notch, // Second notch enabled
   output logic      [6:0]  o_decim,        // Decimation factor
   output logic      [5:0]  o_avg_factor    // Post filter factor
);

   sdf_state_t  st_reg;
   sdf_state_t  st_next;
   logic        tick;
   logic        chop;
   logic        run_avg;
   logic [5:0]  af;
   logic [6:0]  sf;
   logic [1:0]  n_en;
   logic [15:0] wait_len;
   logic [19:0] period;
   logic [13:0] base;
   logic [2:0]  settle;
   logic        addr_hit;

   // Number of enabled converters
   function automatic logic [1:0] sdf_count(input logic [2:0] en);
      sdf_count = {1'b0, en[0]} + {1'b0, en[1]} + {1'b0, en[2]};
   endfunction : sdf_count

   // Length of one Sinc3 conversion in modulator ticks
   function automatic logic [13:0] sdf_base(input logic [6:0] d);
      if (d == `SDF_SF_60HZ) begin
         sdf_base = 14'(`SDF_PERIOD_60HZ);
      end else if (d == `SDF_SF_50HZ) begin
         sdf_base = 14'(`SDF_PERIOD_50HZ);
      end else begin
         sdf_base = 14'(({7'h00, d} + 14'h0001) * `SDF_BASE_MUL);
      end
   endfunction : sdf_base

   // Output period in modulator ticks
   function automatic logic [19:0] sdf_period(input logic [6:0] d,
                                              input logic [5:0] a,
                                              input logic       c);
      logic [20:0] full;
      logic [6:0]  fac;
      fac = 7'h01;
      // Chop alone slows by three; with a factor the rate is unchanged
      if (a != 6'h00 || c) begin
         fac = 7'({1'b0, a} + `SDF_AF_OFFSET);
      end
      if (d == `SDF_SF_60HZ || d == `SDF_SF_50HZ) begin
         fac = 7'h01;
      end
      // Widen both operands first so the product is not cut to 14 bits
      full = 21'(sdf_base(d)) * 21'(fac);
      // Datapath limit on the slowest rate; ticks slow in low power too
      if (full > 21'(`SDF_PERIOD_MAX)) begin
         full = 21'(`SDF_PERIOD_MAX);
      end
      sdf_period = full[19:0];
   endfunction : sdf_period

   // Output periods until the filter has settled
   function automatic logic [2:0] sdf_settle(input logic [5:0] a,
                                             input logic       c,
                                             input logic       r);
      if (c) begin
         sdf_settle = `SDF_SETTLE_CHOP;
      end else begin
         sdf_settle = (a != 6'h00) ? `SDF_SETTLE_AVG
                                   : `SDF_SETTLE_PLAIN;
         if (r) begin
            sdf_settle = sdf_settle + `SDF_SETTLE_RUNAVG;
         end
      end
   endfunction : sdf_settle

   // Modulator tick, 512 kHz or 131 kHz
   sdf_div u_div (
      .i_clock   (i_clock),
      .i_rst     (i_rst),
      .i_lp_mode (i_lp_mode),
      .o_tick    (tick)
   );

   // Field decode of the stored configuration
   assign chop     = st_reg.cfg_reg[`SDF_CHOP_BIT];
   assign run_avg  = st_reg.cfg_reg[`SDF_RUNAVG_BIT] | chop;
   assign af       = st_reg.cfg_reg[`SDF_AF_MSB:`SDF_AF_LSB];
   assign sf       = st_reg.cfg_reg[`SDF_SF_MSB:`SDF_SF_LSB];
   assign n_en     = sdf_count(i_adc_enable);
   assign wait_len = 16'(STARTUP_CYCLES * int'(n_en));
   assign period   = sdf_period(sf, af, chop);
   assign base     = sdf_base(sf);
   assign settle   = sdf_settle(af, chop, run_avg);
   assign addr_hit = (i_addr == `SDF_CFG_ADDR);

   // Next state: bus access, startup wait, output pacing
   always_comb begin
      st_next = st_reg;
      st_next.conv_reset = 1'b0;
      st_next.strobe     = 1'b0;
      st_next.rd_data    = 16'h0000;
      st_next.tick_q     = tick;

      // Read data stand for one cycle only; unmapped reads give zero
      if (i_rd && addr_hit) begin
         st_next.rd_data = st_reg.cfg_reg;
      end

      case (st_reg.phase)
         SDF_WAIT: begin
            // No converter enabled means no result to wait for
            if (n_en == 2'd0) begin
               st_next.wait_cnt = 16'h0000;
            end else if (st_reg.wait_cnt + 16'h0001 >= wait_len) begin
               st_next.phase      = SDF_RUN;
               st_next.wait_cnt   = 16'h0000;
               st_next.period_cnt = 20'h00000;
               st_next.base_cnt   = 14'h0000;
            end else begin
               st_next.wait_cnt = st_reg.wait_cnt + 16'h0001;
            end
         end
         SDF_RUN: begin
            if (n_en == 2'd0) begin
               st_next.phase = SDF_WAIT;
            end else if (tick) begin
               // Chop polarity flips on every Sinc3 conversion
               if (st_reg.base_cnt + 14'h0001 >= base) begin
                  st_next.base_cnt = 14'h0000;
                  if (chop) begin
                     st_next.chop_phase = ~st_reg.chop_phase;
                  end
               end else begin
                  st_next.base_cnt = st_reg.base_cnt + 14'h0001;
               end
               // Compare with >= so a shortened period wraps at once
               if (st_reg.period_cnt + 20'h00001 >= period) begin
                  st_next.period_cnt = 20'h00000;
                  st_next.strobe     = 1'b1;
                  if (st_reg.settle_cnt < settle) begin
                     st_next.settle_cnt = st_reg.settle_cnt + 3'd1;
                  end
                  if (st_reg.settle_cnt + 3'd1 >= settle) begin
                     st_next.settled = 1'b1;
                  end
               end else begin
                  st_next.period_cnt = st_reg.period_cnt + 20'h00001;
               end
            end
         end
         default: begin
            st_next.phase = SDF_WAIT;
         end
      endcase

      // Any write to the register address, even of the same value, restarts all converters
      if (i_wr && addr_hit) begin
         st_next.cfg_reg    = i_wr_data;
         st_next.conv_reset = 1'b1;
         st_next.phase      = SDF_WAIT;
         st_next.wait_cnt   = 16'h0000;
         st_next.period_cnt = 20'h00000;
         st_next.base_cnt   = 14'h0000;
         st_next.chop_phase = 1'b0;
         st_next.settle_cnt = 3'd0;
         st_next.settled    = 1'b0;
      end
   end

   // State register; reset acts like a configuration write of the default
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_reg            <= '0;
         st_reg.cfg_reg    <= `SDF_CFG_RESET;
         st_reg.conv_reset <= 1'b1;
         st_reg.phase      <= SDF_WAIT;
      end else begin
         st_reg <= st_next;
      end
   end

   // Output registers
   logic        chop_q;
   logic        run_avg_q;
   logic        notch_q;
   logic [6:0]  sf_q;
   logic [5:0]  af_q;

   // Configuration levels, registered so outputs come from flip-flops;
   // reset loads the default fields so the levels do not jump on release
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         chop_q    <= 1'b0;
         run_avg_q <= 1'b0;
         notch_q   <= 1'b0;
         sf_q      <= 7'(`SDF_CFG_RESET);
         af_q      <= 6'h00;
      end else begin
         chop_q    <= st_next.cfg_reg[`SDF_CHOP_BIT];
         run_avg_q <= st_next.cfg_reg[`SDF_RUNAVG_BIT]
                      | st_next.cfg_reg[`SDF_CHOP_BIT];
         notch_q   <= st_next.cfg_reg[`SDF_NOTCH_BIT];
         sf_q      <= st_next.cfg_reg[`SDF_SF_MSB:`SDF_SF_LSB];
         af_q      <= st_next.cfg_reg[`SDF_AF_MSB:`SDF_AF_LSB];
      end
   end

   assign o_rd_data      = st_reg.rd_data;
   assign o_conv_reset   = st_reg.conv_reset;
   assign o_mod_tick     = st_reg.tick_q;
   assign o_result       = st_reg.strobe;
   assign o_settled      = st_reg.settled;
   assign o_chop_phase   = st_reg.chop_phase;
   assign o_chop         = chop_q;
   assign o_run_avg      = run_avg_q;
   assign o_second_notch = notch_q;
   assign o_decim        = sf_q;
   assign o_avg_factor   = af_q;

endmodule : sdf_ctrl

`default_nettype wire

// >>> rtl/sdf_div.sv
/*
 * Modulator tick divider: a one-cycle enable at 512 kHz, or at 131 kHz in
 * the low power modes, made from the 125 MHz clock by a phase accumulator.
 * Assumes the power mode input is on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module sdf_div
   import sdf_pkg::*;
(
   input  wire logic i_clock,    // System clock
   input  wire logic i_rst,      // Synchronous reset, active high
   input  wire logic i_lp_mode,  // Low power or low power plus mode
   output logic      o_tick      // Modulator tick enable
);

   sdf_div_state_t st_reg;
   sdf_div_state_t st_next;
   logic [26:0]    inc;
   logic [26:0]    sum;

   // Fractional division keeps the average rate exact; jitter is one cycle
   always_comb begin
      inc = i_lp_mode ? `SDF_LP_HZ : `SDF_MOD_HZ;
      sum = st_reg.acc + inc;
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (sum >= `SDF_CLK_HZ) begin
         st_next.acc  = sum - `SDF_CLK_HZ;
         st_next.tick = 1'b1;
      end else begin
         st_next.acc = sum;
      end
   end

   // State register
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_tick = st_reg.tick;

endmodule : sdf_div

`default_nettype wire

// >>> rtl/sdf_pkg.sv
/*
 * Types of the decimation filter control block.
 * Assumes sdf_cfg.svh is on the include path.
 */
`include "sdf_cfg.svh"

package sdf_pkg;

   // Startup wait after a converter reset, then free running
   typedef enum logic {
      SDF_WAIT,
      SDF_RUN
   } sdf_phase_t;

   // State of the control module, apart from its output registers
   typedef struct packed {
      logic [15:0] cfg_reg;
      logic [15:0] rd_data;
      logic        conv_reset;
      sdf_phase_t  phase;
      logic [15:0] wait_cnt;
      logic [19:0] period_cnt;
      logic [13:0] base_cnt;
      logic        chop_phase;
      logic [2:0]  settle_cnt;
      logic        settled;
      logic        strobe;
      logic        tick_q;
   } sdf_state_t;

   // Whole state of the modulator tick divider
   typedef struct packed {
      logic [26:0] acc;
      logic        tick;
   } sdf_div_state_t;

endpackage : sdf_pkg

// >>> tb/sdf_ctrl_monitor.sv
/* Port checker for the decimation filter control block.
   Assumes one clock, a synchronous active-high reset, and a bind from tb. */
`timescale 1ns/1ns
`default_nettype none
`include "sdf_cfg.svh"
module sdf_ctrl_monitor
#(
   parameter int STARTUP_CYCLES = 10  // Per converter
)
(
   input wire logic        i_clock,        // System clock
   input wire logic        i_rst,          // Synchronous reset
   input wire logic [31:0] i_addr,         // Register address
   input wire logic [15:0] i_wr_data,      // Write data
   input wire logic        i_wr,           // Write strobe
   input wire logic        i_rd,           // Read strobe
   input wire logic [2:0]  i_adc_enable,   // Converter enables
   input wire logic        i_lp_mode,      // Low power mode
   input wire logic [15:0] o_rd_data,      // Read data
   input wire logic        o_conv_reset,   // Converter reset pulse
   input wire logic        o_mod_tick,     // Modulator tick
   input wire logic        o_result,       // Result pulse
   input wire logic        o_settled,      // Settled level
   input wire logic        o_chop,         // Chopping active
   input wire logic        o_chop_phase,   // Chop polarity
   input wire logic        o_run_avg,      // Average-by-2 active
   input wire logic        o_second_notch, // Second notch
   input wire logic [6:0]  o_decim,        // Decimation factor
   input wire logic [5:0]  o_avg_factor    // Averaging factor
);
   logic [31:0] since_reg;  // Cycles since the last converter reset
   logic        wr_hit;
   int          n_en;

   // Enabled converter count and mapped write decode
   assign n_en = int'(i_adc_enable[0]) + int'(i_adc_enable[1])
                 + int'(i_adc_enable[2]);
   assign wr_hit = i_wr && (i_addr == `SDF_CFG_ADDR);

   // Saturating age counter, so a long run never wraps to a small value
   always_ff @(posedge i_clock) begin
      if (i_rst || o_conv_reset) since_reg <= 32'h0;
      else if (since_reg != 32'hffffffff) since_reg <= since_reg + 32'h1;
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   AST_WR_RESET: assert property (wr_hit |=> o_conv_reset && !o_settled)
      else $error("mapped write gave no converter reset");
   AST_UNMAPPED_WR: assert property (i_wr && !wr_hit |=> !o_conv_reset)
      else $error("unmapped write reset the converters");
   AST_STARTUP: assert property (o_result |-> since_reg >= STARTUP_CYCLES * n_en)
      else $error("result before converter startup elapsed");
   AST_CHOP: assert property (wr_hit |=> o_chop == $past(i_wr_data[15]))
      else $error("chop output does not follow write");
   AST_RUNAVG: assert property (wr_hit |=> o_run_avg == ($past(i_wr_data[14]) | $past(i_wr_data[15])))
      else $error("running average not forced by chop");
   AST_AF: assert property (wr_hit |=> o_avg_factor == $past(i_wr_data[13:8]))
      else $error("averaging factor does not follow write");
   AST_NOTCH: assert property (wr_hit |=> o_second_notch == $past(i_wr_data[7]))
      else $error("second notch does not follow write");
   AST_HOLD: assert property (!wr_hit |=> $stable(o_decim) && $stable(o_chop))
      else $error("configuration changed without a write");
   AST_TICK_GAP: assert property (o_mod_tick && !i_lp_mode |=> !o_mod_tick [*8])
      else $error("modulator ticks too close together");
endmodule : sdf_ctrl_monitor
`default_nettype wire

// >>> tb/tb.sv
/* Self-checking bench for the decimation filter control block.
   Assumes the design compiles with a short startup count. */
`timescale 1ns/1ns
`default_nettype none
`include "sdf_cfg.svh"
module tb;
   localparam int STARTUP = 10;  // Short startup keeps the run brief
   localparam logic [15:0] FIELD_VALS [3] = '{16'h81a5, 16'h4000, 16'h0000};
   logic i_clock = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
   logic [31:0] i_addr = 32'h0;
   logic [15:0] i_wr_data = 16'h0;
   logic [2:0]  i_adc_enable = 3'h3;  // Two converters enabled
   logic        i_lp_mode = 1'b0;
   logic [15:0] o_rd_data;
   logic [6:0]  o_decim;
   logic [5:0]  o_avg_factor;
   logic o_conv_reset, o_mod_tick, o_result, o_settled, o_chop;
   logic o_chop_phase, o_run_avg, o_second_notch;
   int miscompares = 0, n_compared = 0;

   sdf_ctrl #(.STARTUP_CYCLES(STARTUP)) u_dut (.i_clock(i_clock),
      .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
      .i_rd(i_rd), .i_adc_enable(i_adc_enable), .i_lp_mode(i_lp_mode),
      .o_rd_data(o_rd_data), .o_conv_reset(o_conv_reset),
      .o_mod_tick(o_mod_tick), .o_result(o_result), .o_settled(o_settled),
      .o_chop(o_chop), .o_chop_phase(o_chop_phase), .o_run_avg(o_run_avg),
      .o_second_notch(o_second_notch), .o_decim(o_decim),
      .o_avg_factor(o_avg_factor));

   // 125 MHz clock
   always #4 i_clock = ~i_clock;

   task cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp

   task bus_write(input logic [31:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_addr <= a; i_wr_data <= d; i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
      #1;
   endtask : bus_write

   // Read data stand only in the cycle after the strobe
   task bus_read(input logic [31:0] a, output logic [15:0] d);
      @(posedge i_clock);
      i_addr <= a; i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 d = o_rd_data;
   endtask : bus_read

   // Counts modulator ticks up to the next result, bounded
   task wait_res(output int ticks);
      ticks = 0;
      for (int k = 0; k < 60000; k++) begin
         @(negedge i_clock);
         if (o_mod_tick === 1'b1) ticks++;
         if (o_result === 1'b1) break;
      end
   endtask : wait_res

   task t_regs;
      logic [15:0] d;
      bus_read(`SDF_CFG_ADDR, d);
      cmp("reset value", 32'h0007, d);
      bus_write(32'hffff051c, 16'hffff);
      cmp("unmapped write reset", 32'h0, o_conv_reset);
      bus_read(`SDF_CFG_ADDR, d);
      cmp("value after unmapped write", 32'h0007, d);
      bus_read(32'hffff051c, d);
      cmp("unmapped read", 32'h0, d);
   endtask : t_regs

   // Stimulus keeps allowed pairs, two converters
   task t_fields;
      logic [15:0] v, d;
      for (int i = 0; i < 3; i++) begin
         v = FIELD_VALS[i];
         bus_write(`SDF_CFG_ADDR, v);
         cmp("converter reset", 32'h1, o_conv_reset);
         cmp("chop", v[15], o_chop);
         cmp("running average", v[15] | v[14], o_run_avg);
         cmp("averaging factor", v[13:8], o_avg_factor);
         cmp("second notch", v[7], o_second_notch);
         cmp("decimation", v[6:0], o_decim);
         bus_read(`SDF_CFG_ADDR, d);
         cmp("read back", v, d);
      end
   endtask : t_fields

   // Plain filter at decimation 0: 64 ticks a result, settled on the third
   task t_plain;
      int t;
      bus_write(`SDF_CFG_ADDR, 16'h0000);
      wait_res(t);
      cmp("settled after one", 32'h0, o_settled);
      for (int i = 0; i < 2; i++) begin
         wait_res(t);
         cmp("plain interval", `SDF_BASE_MUL, t);
      end
      cmp("settled after three", 32'h1, o_settled);
   endtask : t_plain

   // Chop with zero averaging cuts the rate to a third; tick jitter is one
   task t_chop;
      int t, e;
      e = 3 * `SDF_BASE_MUL;
      bus_write(`SDF_CFG_ADDR, 16'h8000);
      wait_res(t);
      cmp("chop first result window", 32'h1, (t >= e - 1 && t <= e + 1));
      cmp("chop settled after one", 32'h0, o_settled);
      cmp("chop phase after three", 32'h1, o_chop_phase);
   endtask : t_chop

   task test_done;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   initial begin
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      t_regs();
      t_fields();
      t_plain();
      t_chop();
      test_done();
   end

   // Watchdog just beyond the expected 94k cycles
   initial begin
      repeat (100000) @(posedge i_clock);
      miscompares++;
      test_done();
   end
endmodule : tb

bind sdf_ctrl sdf_ctrl_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_mon (
   .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
   .i_wr(i_wr), .i_rd(i_rd), .i_adc_enable(i_adc_enable),
   .i_lp_mode(i_lp_mode), .o_rd_data(o_rd_data),
   .o_conv_reset(o_conv_reset), .o_mod_tick(o_mod_tick),
   .o_result(o_result), .o_settled(o_settled), .o_chop(o_chop),
   .o_chop_phase(o_chop_phase), .o_run_avg(o_run_avg),
   .o_second_notch(o_second_notch), .o_decim(o_decim),
   .o_avg_factor(o_avg_factor));
`default_nettype wire
